// ---- core/cpt_defines.svh ----
// constants for the coil chopping timing block
// Summary of operation
// - without wobble chop at 20, 30 or 40 kHz by the frequency select code
// - with wobble dither around 19.5, 29.2 or 39 kHz by 0.5, 0.8, 1 kHz
// - dead-time between switch off and complement on: 0.9/1.2/1.8/4.8 us
// - short blanking after each switching event: 1, 1.2 or 1.8 us by speed
// - blanking is 4 us when long blanking set or speed code is 00
// - comparator must persist 0.5, 1, 2 or 3 us before regulation acts
// - extended filter option adds 0.2 us to every filter time
`ifndef CPT_DEFINES_SVH
`define CPT_DEFINES_SVH

`define CPT_CLK_HZ 40000000
`define CPT_CLK_MHZ 40
// least times round up to whole cycles
`define CPT_NS2CYC(ns) ((((ns) * `CPT_CLK_MHZ) + 999) / 1000)
`define CPT_HZ2CYC(hz) (`CPT_CLK_HZ / (hz))
`define CPT_WOBDEV(c, s) \
    ((`CPT_HZ2CYC((c) - (s)) - `CPT_HZ2CYC((c) + (s))) / 2)

// chopping frequencies in Hz
`define CPT_F0_HZ 20000
`define CPT_F1_HZ 30000
`define CPT_F2_HZ 40000
`define CPT_FW0_HZ 19500
`define CPT_FW1_HZ 29200
`define CPT_FW2_HZ 39000
`define CPT_SW0_HZ 500
`define CPT_SW1_HZ 800
`define CPT_SW2_HZ 1000
`define CPT_WOB_STEP 1

// dead-times in ns by switching speed code
`define CPT_DT11_NS 900
`define CPT_DT10_NS 1200
`define CPT_DT01_NS 1800
`define CPT_DT00_NS 4800
// blanking times in ns
`define CPT_BL11_NS 1000
`define CPT_BL10_NS 1200
`define CPT_BL01_NS 1800
`define CPT_BLLONG_NS 4000
// regulation filter times in ns
`define CPT_FT00_NS 500
`define CPT_FT01_NS 1000
`define CPT_FT10_NS 2000
`define CPT_FT11_NS 3000
`define CPT_FTEXT_NS 200

// register map, byte addresses
`define CPT_CFG_ADDR 4'h0
`define CPT_STAT_ADDR 4'h4
`define CPT_CFG_RST 10'h000
// configuration fields
`define CPT_CFG_CHOP_LSB 0
`define CPT_CFG_WOB_BIT 2
`define CPT_CFG_SP_LSB 3
`define CPT_CFG_LBL_BIT 5
`define CPT_CFG_FS_LSB 6
`define CPT_CFG_FTX_BIT 8
`define CPT_CFG_EN_BIT 9
`define CPT_CFG_W 10

`endif

// ---- core/cpt_pkg.sv ----
// types shared by the coil chopping timing block
package cpt_pkg;
    typedef logic [11:0] cpt_cnt_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEAD_HS,
        ST_HS,
        ST_DEAD_LS,
        ST_LS
    } cpt_state_e;
endpackage : cpt_pkg

// ---- core/cpt_qual_if.sv ----
// link between bridge sequencer and comparator qualifier
`timescale 1ns/1ps
`default_nettype none
interface cpt_qual_if;
    import cpt_pkg::*;
    logic blankStart;
    cpt_cnt_t blankCyc;
    cpt_cnt_t filtCyc;
    logic blanking;
    logic tripped;
    modport seq (output blankStart, blankCyc, filtCyc,
        input blanking, tripped);
    modport qual (input blankStart, blankCyc, filtCyc,
        output blanking, tripped);
endinterface : cpt_qual_if
`default_nettype wire

// ---- core/cpt_comp_qual.sv ----
// current comparator blanking and persistence filter
`timescale 1ns/1ps
`default_nettype none
module cpt_comp_qual
    import cpt_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic compRaw,
    cpt_qual_if.qual q
);
    logic syncA_r;
    logic syncB_r;
    cpt_cnt_t blankCnt_r, blankCnt_nxt;
    cpt_cnt_t filtCnt_r, filtCnt_nxt;
    logic blanking_r, blanking_nxt;
    logic tripped_r, tripped_nxt;
    logic tripSet;

    ////////////////////////////////////////////////////////////////////
    // pin synchroniser, first stage read only by the second
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_r <= 1'b0;
            syncB_r <= 1'b0;
        end else begin
            syncA_r <= compRaw;
            syncB_r <= syncA_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // blanking window and filter count
    always_comb begin
        blankCnt_nxt = blankCnt_r;
        if (q.blankStart) begin
            blankCnt_nxt = q.blankCyc;
        end else if (blankCnt_r != '0) begin
            blankCnt_nxt = blankCnt_r - 1'b1;
        end
        blanking_nxt = (blankCnt_nxt != '0);
        // the comparator must stay high for filtCyc unblanked samples
        tripSet = !blanking_r && syncB_r &&
            (filtCnt_r == q.filtCyc - 1'b1);
        if (q.blankStart || blanking_r || !syncB_r) begin
            filtCnt_nxt = '0;
        end else if (tripSet) begin
            filtCnt_nxt = filtCnt_r;
        end else begin
            filtCnt_nxt = filtCnt_r + 1'b1;
        end
        // new switching event clears the trip; blanking masks any set
        tripped_nxt = q.blankStart ? 1'b0 : (tripped_r | tripSet);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            blankCnt_r <= '0;
            filtCnt_r <= '0;
            blanking_r <= 1'b0;
            tripped_r <= 1'b0;
        end else begin
            blankCnt_r <= blankCnt_nxt;
            filtCnt_r <= filtCnt_nxt;
            blanking_r <= blanking_nxt;
            tripped_r <= tripped_nxt;
        end
    end

    assign q.blanking = blanking_r;
    assign q.tripped = tripped_r;
endmodule : cpt_comp_qual
`default_nettype wire

// ---- core/cpt_core.sv ----
// coil chopping timing: period, wobble, dead-time, blanking, filter
`timescale 1ns/1ps
`default_nettype none
`include "cpt_defines.svh"
module cpt_core
    import cpt_pkg::*;
#(
    parameter int WOB_STEP = `CPT_WOB_STEP
)(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [31:0] regRdData,
    input wire logic compRaw,
    output logic highSideOn,
    output logic lowSideOn,
    output logic chopStart,
    output logic compBlanked,
    output logic compTripped
);
    ////////////////////////////////////////////////////////////////////
    // elaboration checks: every period must fit the counter width
    localparam int MAX_CYC = `CPT_HZ2CYC(`CPT_FW0_HZ - `CPT_SW0_HZ);
    localparam int MIN_DEV = `CPT_WOBDEV(`CPT_FW2_HZ, `CPT_SW2_HZ);
    if (MAX_CYC >= 4096) begin : g_chkWidth
        $error("chop period does not fit counter");
    end
    if (WOB_STEP < 1 || WOB_STEP > MIN_DEV) begin : g_chkStep
        $error("wobble step out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // interval tables, all counts in system clock cycles
    function automatic cpt_cnt_t perCyc(input logic [1:0] sel);
        case (sel)
            2'b00: perCyc = cpt_cnt_t'(`CPT_HZ2CYC(`CPT_F0_HZ));
            2'b01: perCyc = cpt_cnt_t'(`CPT_HZ2CYC(`CPT_F1_HZ));
            default: perCyc = cpt_cnt_t'(`CPT_HZ2CYC(`CPT_F2_HZ));
        endcase
    endfunction : perCyc

    function automatic cpt_cnt_t wobCentre(input logic [1:0] sel);
        case (sel)
            2'b00: wobCentre = cpt_cnt_t'(`CPT_HZ2CYC(`CPT_FW0_HZ));
            2'b01: wobCentre = cpt_cnt_t'(`CPT_HZ2CYC(`CPT_FW1_HZ));
            default: wobCentre = cpt_cnt_t'(`CPT_HZ2CYC(`CPT_FW2_HZ));
        endcase
    endfunction : wobCentre

    function automatic cpt_cnt_t wobDev(input logic [1:0] sel);
        case (sel)
            2'b00: wobDev =
                cpt_cnt_t'(`CPT_WOBDEV(`CPT_FW0_HZ, `CPT_SW0_HZ));
            2'b01: wobDev =
                cpt_cnt_t'(`CPT_WOBDEV(`CPT_FW1_HZ, `CPT_SW1_HZ));
            default: wobDev =
                cpt_cnt_t'(`CPT_WOBDEV(`CPT_FW2_HZ, `CPT_SW2_HZ));
        endcase
    endfunction : wobDev

    function automatic cpt_cnt_t deadCyc(input logic [1:0] sp);
        case (sp)
            2'b11: deadCyc = cpt_cnt_t'(`CPT_NS2CYC(`CPT_DT11_NS));
            2'b10: deadCyc = cpt_cnt_t'(`CPT_NS2CYC(`CPT_DT10_NS));
            2'b01: deadCyc = cpt_cnt_t'(`CPT_NS2CYC(`CPT_DT01_NS));
            default: deadCyc = cpt_cnt_t'(`CPT_NS2CYC(`CPT_DT00_NS));
        endcase
    endfunction : deadCyc

    function automatic cpt_cnt_t blankCyc(input logic [1:0] sp,
            input logic longBl);
        if (longBl || sp == 2'b00) begin
            blankCyc = cpt_cnt_t'(`CPT_NS2CYC(`CPT_BLLONG_NS));
        end else begin
            case (sp)
                2'b11: blankCyc = cpt_cnt_t'(`CPT_NS2CYC(`CPT_BL11_NS));
                2'b10: blankCyc = cpt_cnt_t'(`CPT_NS2CYC(`CPT_BL10_NS));
                default: blankCyc = cpt_cnt_t'(`CPT_NS2CYC(`CPT_BL01_NS));
            endcase
        end
    endfunction : blankCyc

    function automatic cpt_cnt_t filtCyc(input logic [1:0] fs,
            input logic ext);
        int ns;
        case (fs)
            2'b00: ns = `CPT_FT00_NS;
            2'b01: ns = `CPT_FT01_NS;
            2'b10: ns = `CPT_FT10_NS;
            default: ns = `CPT_FT11_NS;
        endcase
        if (ext) begin
            ns = ns + `CPT_FTEXT_NS;
        end
        filtCyc = cpt_cnt_t'(`CPT_NS2CYC(ns));
    endfunction : filtCyc

    ////////////////////////////////////////////////////////////////////
    // configuration register and read port
    logic [`CPT_CFG_W-1:0] cfg_r, cfg_nxt;
    logic [31:0] rdData_r, rdData_nxt;
    logic [1:0] chop_select_a;
    logic chop_wobble_enable;
    logic [1:0] switch_speed_select;
    logic long_blank_enable;
    logic [1:0] comparator_filter_select;
    logic filter_extend_enable;
    logic chopEnable;
    cpt_state_e state_r, state_nxt;
    logic highSideOn_r, highSideOn_nxt;
    logic lowSideOn_r, lowSideOn_nxt;
    logic blankStart_r, blankStart_nxt;
    cpt_cnt_t deadCnt_r, deadCnt_nxt;
    cpt_cnt_t perCnt_r, perCnt_nxt;
    cpt_cnt_t wobOff_r, wobOff_nxt;
    logic wobUp_r, wobUp_nxt;
    logic chopStart_r, chopStart_nxt;
    cpt_cnt_t perLen;
    cpt_cnt_t devCyc;
    cpt_cnt_t wobCur, wobMax;
    logic chopTick;
    cpt_qual_if qIf();

    assign chop_select_a = cfg_r[`CPT_CFG_CHOP_LSB +: 2];
    assign chop_wobble_enable = cfg_r[`CPT_CFG_WOB_BIT];
    assign switch_speed_select = cfg_r[`CPT_CFG_SP_LSB +: 2];
    assign long_blank_enable = cfg_r[`CPT_CFG_LBL_BIT];
    assign comparator_filter_select = cfg_r[`CPT_CFG_FS_LSB +: 2];
    assign filter_extend_enable = cfg_r[`CPT_CFG_FTX_BIT];
    assign chopEnable = cfg_r[`CPT_CFG_EN_BIT];

    // writes take effect at once; timing follows the live fields
    always_comb begin
        cfg_nxt = cfg_r;
        rdData_nxt = '0;
        if (regWrStb && regAddr == `CPT_CFG_ADDR) begin
            cfg_nxt = regWrData[`CPT_CFG_W-1:0];
        end
        if (regRdStb) begin
            case (regAddr)
                `CPT_CFG_ADDR: rdData_nxt = {22'h000000, cfg_r};
                `CPT_STAT_ADDR: rdData_nxt = {4'h0, perCnt_r,
                    9'h000, state_r, qIf.tripped, qIf.blanking,
                    lowSideOn_r, highSideOn_r};
                default: rdData_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= `CPT_CFG_RST;
            rdData_r <= '0;
        end else begin
            cfg_r <= cfg_nxt;
            rdData_r <= rdData_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // chopping period counter with triangular wobble
    always_comb begin
        devCyc = wobDev(chop_select_a);
        wobMax = devCyc << 1;
        wobCur = (wobOff_r > wobMax) ? wobMax : wobOff_r;
        if (chop_wobble_enable) begin
            // offset clamped to the band after a code change
            perLen = wobCentre(chop_select_a) - devCyc + wobCur;
        end else begin
            perLen = perCyc(chop_select_a);
        end
        chopTick = chopEnable && (perCnt_r == '0);
        perCnt_nxt = perCnt_r;
        wobOff_nxt = wobOff_r;
        wobUp_nxt = wobUp_r;
        if (!chopEnable) begin
            perCnt_nxt = '0;
        end else if (chopTick) begin
            perCnt_nxt = perLen - 1'b1;
            if (!chop_wobble_enable) begin
                wobOff_nxt = devCyc;
            end else if (wobUp_r) begin
                if (wobCur + cpt_cnt_t'(WOB_STEP) >= wobMax) begin
                    wobOff_nxt = wobMax;
                    wobUp_nxt = 1'b0;
                end else begin
                    wobOff_nxt = wobCur + cpt_cnt_t'(WOB_STEP);
                end
            end else begin
                if (wobCur <= cpt_cnt_t'(WOB_STEP)) begin
                    wobOff_nxt = '0;
                    wobUp_nxt = 1'b1;
                end else begin
                    wobOff_nxt = wobCur - cpt_cnt_t'(WOB_STEP);
                end
            end
        end else begin
            perCnt_nxt = perCnt_r - 1'b1;
        end
        chopStart_nxt = chopTick;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            perCnt_r <= '0;
            wobOff_r <= '0;
            wobUp_r <= 1'b1;
            chopStart_r <= 1'b0;
        end else begin
            perCnt_r <= perCnt_nxt;
            wobOff_r <= wobOff_nxt;
            wobUp_r <= wobUp_nxt;
            chopStart_r <= chopStart_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bridge sequencer: both switches off for the dead-time before
    // either turns on, so the leg can never conduct straight through
    always_comb begin
        state_nxt = state_r;
        deadCnt_nxt = deadCnt_r;
        blankStart_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (chopTick) begin
                    state_nxt = ST_DEAD_HS;
                    deadCnt_nxt = deadCyc(switch_speed_select) - 1'b1;
                end
            end
            ST_DEAD_HS: begin
                if (deadCnt_r == '0) begin
                    state_nxt = ST_HS;
                    blankStart_nxt = 1'b1;
                end else begin
                    deadCnt_nxt = deadCnt_r - 1'b1;
                end
            end
            ST_HS: begin
                // stays on through a period end until the current trips
                if (qIf.tripped && !blankStart_r) begin
                    state_nxt = ST_DEAD_LS;
                    deadCnt_nxt = deadCyc(switch_speed_select) - 1'b1;
                end
            end
            ST_DEAD_LS: begin
                if (deadCnt_r == '0) begin
                    state_nxt = ST_LS;
                    blankStart_nxt = 1'b1;
                end else begin
                    deadCnt_nxt = deadCnt_r - 1'b1;
                end
            end
            ST_LS: begin
                if (chopTick) begin
                    state_nxt = ST_DEAD_HS;
                    deadCnt_nxt = deadCyc(switch_speed_select) - 1'b1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (!chopEnable) begin
            state_nxt = ST_IDLE;
            blankStart_nxt = 1'b0;
        end
        highSideOn_nxt = (state_nxt == ST_HS);
        lowSideOn_nxt = (state_nxt == ST_LS);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            deadCnt_r <= '0;
            blankStart_r <= 1'b0;
            highSideOn_r <= 1'b0;
            lowSideOn_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            deadCnt_r <= deadCnt_nxt;
            blankStart_r <= blankStart_nxt;
            highSideOn_r <= highSideOn_nxt;
            lowSideOn_r <= lowSideOn_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // comparator qualification
    assign qIf.blankStart = blankStart_r;
    assign qIf.blankCyc = blankCyc(switch_speed_select,
        long_blank_enable);
    assign qIf.filtCyc = filtCyc(comparator_filter_select,
        filter_extend_enable);

    cpt_comp_qual u_qual (
        .mclk(mclk),
        .arst_n(arst_n),
        .compRaw(compRaw),
        .q(qIf.qual)
    );

    // outputs straight from flip-flops
    assign regRdData = rdData_r;
    assign highSideOn = highSideOn_r;
    assign lowSideOn = lowSideOn_r;
    assign chopStart = chopStart_r;
    assign compBlanked = qIf.blanking;
    assign compTripped = qIf.tripped;
endmodule : cpt_core
`default_nettype wire

// ---- tb/cpt_tb_pkg.sv ----
// expected interval counts for the chopping bench at 40 MHz
package cpt_tb_pkg;
    // dead-time by switching speed code
    function automatic int dead_of(input logic [1:0] sp);
        return (sp == 2'h3) ? 36 : (sp == 2'h2) ? 48 : (sp == 2'h1) ? 72 : 192;
    endfunction : dead_of
    // the slowest speed always takes the long blank
    function automatic int blank_of(input logic [1:0] sp, input logic lb);
        if (lb || sp == 2'h0) return 160;
        return (sp == 2'h3) ? 40 : (sp == 2'h2) ? 48 : 72;
    endfunction : blank_of
    function automatic int filt_of(input logic [1:0] fc, input logic fx);
        int b;
        b = (fc == 2'h0) ? 20 : (fc == 2'h1) ? 40 : (fc == 2'h2) ? 80 : 120;
        return fx ? b + 8 : b;
    endfunction : filt_of
    function automatic int per_of(input logic [1:0] fq);
        return fq[1] ? 1000 : fq[0] ? 1333 : 2000;
    endfunction : per_of
    // wobble band is centre minus and plus the deviation
    function automatic int wlo_of(input logic [1:0] fq);
        return fq[1] ? 999 : fq[0] ? 1332 : 1999;
    endfunction : wlo_of
    function automatic int whi_of(input logic [1:0] fq);
        return fq[1] ? 1051 : fq[0] ? 1406 : 2103;
    endfunction : whi_of
endpackage : cpt_tb_pkg

// ---- tb/cpt_coil_model.sv ----
// behavioural coil and current comparator behind the bridge
`timescale 1ns/1ps
`default_nettype none
module cpt_coil_model (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic highSideOn,
    input wire logic lowSideOn,
    input wire logic [11:0] riseCyc,
    output logic compRaw
);
    logic [11:0] onCnt_r;
    ////////////////////////////////////////////////////////////////////////
    // current only ramps while the high side conducts; a large riseCyc
    // is a coil too slow to reach the reference inside one period
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            onCnt_r <= 12'h000;
            compRaw <= 1'b0;
        end else begin
            onCnt_r <= !highSideOn ? 12'h000 :
                (onCnt_r == 12'hfff) ? onCnt_r : onCnt_r + 12'h001;
            compRaw <= highSideOn && !lowSideOn && (onCnt_r >= riseCyc);
        end
    end
endmodule : cpt_coil_model
`default_nettype wire

// ---- tb/cpt_core_properties.sv ----
// concurrent checks on the chopping timing block ports
`timescale 1ns/1ps
`default_nettype none
`include "cpt_defines.svh"
module cpt_core_properties
    import cpt_tb_pkg::*;
#(
    parameter int WOB_STEP = 1
)(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [31:0] regRdData,
    input wire logic compRaw,
    input wire logic highSideOn,
    input wire logic lowSideOn,
    input wire logic chopStart,
    input wire logic compBlanked,
    input wire logic compTripped
);
    logic [9:0] cfg_r;
    logic seenCs_r;
    logic cfgWr;
    int csCnt_r, offCnt_r, blCnt_r, rawCnt_r;
    int deadN, blankN, filtN, perN, wLo, wHi;
    ////////////////////////////////////////////////////////////////////////
    // expected counts follow the shadowed configuration
    assign cfgWr = regWrStb && (regAddr == `CPT_CFG_ADDR);
    assign deadN = dead_of(cfg_r[4:3]);
    assign blankN = blank_of(cfg_r[4:3], cfg_r[5]);
    assign filtN = filt_of(cfg_r[7:6], cfg_r[8]);
    assign perN = per_of(cfg_r[1:0]);
    assign wLo = wlo_of(cfg_r[1:0]);
    assign wHi = whi_of(cfg_r[1:0]);
    // a configuration write voids counts until the next period start, since old
    // settings may still be finishing the running phase
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= 10'h000;
            seenCs_r <= 1'b0;
            csCnt_r <= 0;
            offCnt_r <= 0;
            blCnt_r <= 0;
            rawCnt_r <= 0;
        end else begin
            cfg_r <= cfgWr ? regWrData[9:0] : cfg_r;
            seenCs_r <= cfgWr ? 1'b0 : (seenCs_r || chopStart);
            csCnt_r <= chopStart ? 1 : csCnt_r + 1;
            offCnt_r <= (highSideOn || lowSideOn) ? 0 : offCnt_r + 1;
            blCnt_r <= compBlanked ? blCnt_r + 1 : 0;
            rawCnt_r <= compRaw ? rawCnt_r + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_sides_exclusive: assert property (!(highSideOn && lowSideOn))
        else $error("both bridge sides on");
    a_hs_dead: assert property ($rose(highSideOn) && seenCs_r |->
        csCnt_r == deadN) else $error("high side dead-time wrong");
    a_ls_dead: assert property ($rose(lowSideOn) && seenCs_r |->
        offCnt_r == deadN) else $error("low side dead-time wrong");
    a_period_fixed: assert property (chopStart && seenCs_r && !cfg_r[2]
        |-> csCnt_r == perN) else $error("chop period wrong");
    a_period_wobble: assert property (chopStart && seenCs_r && cfg_r[2]
        |-> csCnt_r >= wLo && csCnt_r <= wHi) else $error("wobble band left");
    a_blank_length: assert property ($fell(compBlanked) && seenCs_r
        |-> blCnt_r == blankN) else $error("blanking length wrong");
    a_blank_start: assert property ($rose(highSideOn) || $rose(lowSideOn)
        |=> $rose(compBlanked) && !compTripped) else $error("blank not started");
    a_filter_count: assert property ($rose(compTripped) && seenCs_r
        |-> rawCnt_r == filtN + 2) else $error("filter time wrong");
    a_trip_release: assert property ($rose(compTripped) |-> ##[0:1]
        !highSideOn) else $error("high side kept after trip");
    a_disable_off: assert property (cfgWr && !regWrData[9] |-> ##2
        !highSideOn && !lowSideOn) else $error("bridge on after disable");
    a_read_idle: assert property (!$past(regRdStb) |-> regRdData == 32'h0)
        else $error("read data outside read slot");
    // main scenarios reached
    c_trip: cover property ($rose(compTripped));
    c_ls_on: cover property ($rose(lowSideOn));
    c_wobble: cover property (chopStart && cfg_r[2]);
    c_long_blank: cover property ($fell(compBlanked) && blCnt_r == 160);
endmodule : cpt_core_properties
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the coil chopping timing block
`timescale 1ns/1ps
`default_nettype none
`include "cpt_defines.svh"
module testbench
    import cpt_tb_pkg::*;
;
    logic mclk, arst_n, regWrStb, regRdStb, compRaw;
    logic highSideOn, lowSideOn, chopStart, compBlanked, compTripped;
    logic [3:0] regAddr;
    logic [31:0] regWrData, regRdData, d, c;
    logic [11:0] riseCyc;
    int errorCnt, checked, n, p0, p2;
    cpt_core #(.WOB_STEP(1)) u_dut (.mclk(mclk), .arst_n(arst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData(regRdData), .compRaw(compRaw),
        .highSideOn(highSideOn), .lowSideOn(lowSideOn),
        .chopStart(chopStart), .compBlanked(compBlanked),
        .compTripped(compTripped));
    cpt_coil_model u_coil (.mclk(mclk), .arst_n(arst_n),
        .highSideOn(highSideOn), .lowSideOn(lowSideOn),
        .riseCyc(riseCyc), .compRaw(compRaw));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic finish_test();
        if (errorCnt == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errorCnt++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge mclk);
        regWrStb <= 1'b0;
    endtask : wr
    // read data stand only in the slot after the strobe edge
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRdStb <= 1'b0;
        #1 v = regRdData;
    endtask : rd
    // edges until an output reaches a level
    task automatic wait_for(input int sel, input logic lvl, output int k);
        logic v;
        k = 0;
        do begin
            @(posedge mclk);
            #1 v = (sel == 0) ? chopStart : (sel == 1) ? highSideOn :
                (sel == 2) ? lowSideOn : compBlanked;
            k++;
        end while (v !== lvl && k < 5000);
        if (k >= 5000) begin
            errorCnt++;
            finish_test();
        end
    endtask : wait_for
    // stop the bridge first so no phase straddles two settings
    task automatic apply(input logic [31:0] v);
        wr(`CPT_CFG_ADDR, 32'h0);
        wait_for(3, 1'b0, n);
        riseCyc <= 12'(blank_of(v[4:3], v[5]) + 8);
        wr(`CPT_CFG_ADDR, v);
    endtask : apply
    function automatic logic [31:0] mk(input logic [1:0] fq, input logic wb,
        input logic [1:0] sp, input logic lb, input logic [1:0] fc,
        input logic fx);
        return {22'h0, 1'b1, fx, fc, lb, sp, wb, fq};
    endfunction : mk
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge mclk);
        errorCnt++;
        finish_test();
    end
    initial begin
        arst_n = 1'b0;
        regAddr = 4'h0;
        regWrData = 32'h0;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        riseCyc = 12'h030;
        errorCnt = 0;
        checked = 0;
        repeat (2) @(posedge mclk);
        chk("reset_out", 32'h0, {27'h0, highSideOn, lowSideOn, chopStart,
            compBlanked, compTripped});
        arst_n <= 1'b1;
        rd(`CPT_CFG_ADDR, d);
        chk("cfg_reset", 32'h0, d);
        // upper bits dropped, unmapped writes ignored and read as zero
        wr(`CPT_CFG_ADDR, 32'hffff_fdfe);
        wr(4'h8, 32'hffff_ffff);
        rd(`CPT_CFG_ADDR, d);
        chk("cfg_back", 32'h0000_01fe, d);
        rd(4'h8, d);
        chk("unmapped", 32'h0, d);
        // fixed period for each frequency code, 1x both mean 40 kHz
        for (int i = 0; i < 4; i++) begin
            apply(mk(i[1:0], 1'b0, 2'h3, 1'b0, 2'h0, 1'b0));
            wait_for(0, 1'b1, n);
            wait_for(0, 1'b1, n);
            chk("period", per_of(i[1:0]), n);
        end
        // every speed, blank and filter code, each plain and extended
        for (int i = 0; i < 8; i++) begin
            c = mk(2'h0, 1'b0, i[1:0], i[2], i[1:0], i[2]);
            apply(c);
            wait_for(0, 1'b1, n);
            wait_for(1, 1'b1, n);
            chk("hs_dead", dead_of(i[1:0]), n);
            wait_for(3, 1'b1, n);
            wait_for(3, 1'b0, n);
            chk("blank", blank_of(i[1:0], i[2]), n);
            wait_for(1, 1'b0, n);
            wait_for(2, 1'b1, n);
            chk("ls_dead", dead_of(i[1:0]), n);
        end
        // wobbled periods stay in the band and keep moving
        for (int i = 0; i < 3; i++) begin
            apply(mk(i[1:0], 1'b1, 2'h3, 1'b0, 2'h0, 1'b0));
            wait_for(0, 1'b1, n);
            wait_for(0, 1'b1, p0);
            wait_for(0, 1'b1, n);
            wait_for(0, 1'b1, p2);
            chk("wob_band", 32'h1, 32'(p0 >= wlo_of(i[1:0]) &&
                p2 <= whi_of(i[1:0])));
            chk("wob_moves", 32'h1, 32'(p0 != n || n != p2));
        end
        // status during the high side phase, then disable mid-phase
        apply(mk(2'h0, 1'b0, 2'h3, 1'b0, 2'h0, 1'b0));
        wait_for(1, 1'b1, n);
        rd(`CPT_STAT_ADDR, d);
        chk("stat_sides", 32'h1, {30'h0, d[1:0]});
        chk("stat_state", 32'h2, {29'h0, d[6:4]});
        wr(`CPT_CFG_ADDR, 32'h0);
        @(posedge mclk);
        #1 chk("disable_off", 32'h0, {30'h0, highSideOn, lowSideOn});
        finish_test();
    end
endmodule : testbench
bind cpt_core cpt_core_properties #(.WOB_STEP(WOB_STEP)) u_props (
    .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .compRaw(compRaw), .highSideOn(highSideOn),
    .lowSideOn(lowSideOn), .chopStart(chopStart),
    .compBlanked(compBlanked), .compTripped(compTripped));
`default_nettype wire
